// ### pkg/nfcim_regs.svh
`ifndef NFCIM_REGS_SVH
`define NFCIM_REGS_SVH
// ============================================================
// Register indices (byte address = 4 * index)
`define NFCIM_IDX_MAIN_MASK 6'h16
`define NFCIM_IDX_TF_MASK   6'h17
`define NFCIM_IDX_EW_MASK   6'h18
`define NFCIM_IDX_PT_MASK   6'h19
`define NFCIM_IDX_MAIN_STAT 6'h1a
`define NFCIM_IDX_TF_STAT   6'h1b
`define NFCIM_IDX_EW_STAT   6'h1c
`define NFCIM_IDX_PT_STAT   6'h1d
// ============================================================
// Reset values and implemented bits
`define NFCIM_MASK_RST 8'h00
`define NFCIM_MAIN_USED 8'hfe
`define NFCIM_TF_USED   8'hff
`define NFCIM_EW_USED   8'hfe
`define NFCIM_PT_USED   8'hfb
// ============================================================
// Field positions
`define NFCIM_MAIN_OSC  7
`define NFCIM_MAIN_WL   6
`define NFCIM_MAIN_RXS  5
`define NFCIM_MAIN_RXE  4
`define NFCIM_MAIN_TXE  3
`define NFCIM_MAIN_COL  2
`define NFCIM_MAIN_REST 1
`define NFCIM_TF_DCT  7
`define NFCIM_TF_NRE  6
`define NFCIM_TF_GPE  5
`define NFCIM_TF_EON  4
`define NFCIM_TF_EOF  3
`define NFCIM_TF_CAC  2
`define NFCIM_TF_CAT  1
`define NFCIM_TF_NFCT 0
// ============================================================
// FIFO water levels, timing
`define NFCIM_WL_RX_BYTES 10'h12c
`define NFCIM_WL_TX_BYTES 10'h0c8
`define NFCIM_CLK_NS   5
`define NFCIM_GUARD_NS 1000
`define NFCIM_GUARD_CYC ((`NFCIM_GUARD_NS + `NFCIM_CLK_NS - 1) / `NFCIM_CLK_NS)
`endif

// ### pkg/nfcim_pkg.sv
`default_nettype none
package nfcim_pkg;
  typedef logic [7:0] nfcim_byte_t;
  typedef logic [5:0] nfcim_idx_t;
  typedef logic [9:0] nfcim_count_t;
  typedef enum {CA_IDLE, CA_GUARD} nfcim_ca_t;
endpackage
`default_nettype wire

// ### pkg/nfcim_if.sv
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Sticky flags with mask
interface nfcim_flag_if;
  logic [7:0] set;
  logic [7:0] mask;
  logic       clr;
  logic [7:0] flags;
  logic       pend;
  modport bank (input set, input mask, input clr, output flags, output pend);
  modport ctrl (output set, output mask, output clr, input flags, input pend);
endinterface

// ============================================================
// Register access strobes
interface nfcim_reg_if;
  logic       wr;
  logic [5:0] widx;
  logic [7:0] wdata;
  logic       whit;
  logic       rd;
  logic [5:0] ridx;
  logic [7:0] rdata;
  logic       rhit;
  modport slave (output wr, output widx, output wdata, input whit,
                 output rd, output ridx, input rdata, input rhit);
  modport regs  (input wr, input widx, input wdata, output whit,
                 input rd, input ridx, output rdata, output rhit);
endinterface
`default_nettype wire

// ### logic/nfcim_flag_bank.sv
`timescale 1ns/100ps
`default_nettype none
module nfcim_flag_bank #(
  parameter logic [7:0] USED = 8'hff
) (
  input wire logic    aclk,
  input wire logic    aresetn,
  nfcim_flag_if.bank  fb
);
  logic [7:0] flags_q;
  logic [7:0] flags_d;

  // A set in the clearing cycle survives the read
  always_comb begin
    flags_d = ((fb.clr ? 8'h00 : flags_q) | fb.set) & USED;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= 8'h00;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign fb.flags = flags_q;
  assign fb.pend  = |(flags_q & ~fb.mask);
endmodule
`default_nettype wire

// ### logic/nfcim_axil_slave.sv
`timescale 1ns/100ps
`default_nettype none
module nfcim_axil_slave (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [7:0]   s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [7:0]   s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  nfcim_reg_if.slave        rb
);
  logic       aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
  logic [5:0] aidx_q, aidx_d;
  logic [7:0] wd_q, wd_d;
  logic       ws_q, ws_d;
  logic [1:0] br_q, br_d, rr_q, rr_d;
  logic [7:0] rd_q, rd_d;

  assign s_axi_awready = !aw_q && !bv_q;
  assign s_axi_wready  = !w_q && !bv_q;
  assign s_axi_arready = !rv_q;
  // Write once address and data are held and byte lane 0 was strobed
  assign rb.wr    = aw_q && w_q && !bv_q && ws_q;
  assign rb.widx  = aidx_q;
  assign rb.wdata = wd_q;
  assign rb.rd    = s_axi_arvalid && !rv_q;
  assign rb.ridx  = s_axi_araddr[7:2];

  // ============================================================
  // Channel state
  always_comb begin
    aw_d = aw_q; w_d = w_q; bv_d = bv_q; rv_d = rv_q;
    aidx_d = aidx_q; wd_d = wd_q; ws_d = ws_q;
    br_d = br_q; rr_d = rr_q; rd_d = rd_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_d = 1'b1;
      aidx_d = s_axi_awaddr[7:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_d = 1'b1;
      wd_d = s_axi_wdata[7:0];
      ws_d = s_axi_wstrb[0];
    end
    if (aw_q && w_q && !bv_q) begin
      bv_d = 1'b1;
      aw_d = 1'b0;
      w_d = 1'b0;
      br_d = rb.whit ? 2'h0 : 2'h2;
    end
    if (bv_q && s_axi_bready) begin
      bv_d = 1'b0;
    end
    if (rb.rd) begin
      rv_d = 1'b1;
      rd_d = rb.rdata;
      rr_d = rb.rhit ? 2'h0 : 2'h2;
    end else if (rv_q && s_axi_rready) begin
      rv_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0; w_q <= 1'b0; bv_q <= 1'b0; rv_q <= 1'b0;
      aidx_q <= 6'h00; wd_q <= 8'h00; ws_q <= 1'b0;
      br_q <= 2'h0; rr_q <= 2'h0; rd_q <= 8'h00;
    end else begin
      aw_q <= aw_d; w_q <= w_d; bv_q <= bv_d; rv_q <= rv_d;
      aidx_q <= aidx_d; wd_q <= wd_d; ws_q <= ws_d;
      br_q <= br_d; rr_q <= rr_d; rd_q <= rd_d;
    end
  end

  assign s_axi_bvalid = bv_q;
  assign s_axi_bresp  = br_q;
  assign s_axi_rvalid = rv_q;
  assign s_axi_rresp  = rr_q;
  assign s_axi_rdata  = {24'h000000, rd_q};
endmodule
`default_nettype wire

// ### logic/nfcim_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "nfcim_regs.svh"
// Summary of operation
// RL1: Timer/field mask layout
// RL2: Error/wake mask layout
// RL3: Target mask bits, bit 2 unused
// RL4: Masks reset clear; one blocks request
// RL5: Main status layout
// RL6: Oscillator stable flag after enable
// RL7: Receiving, more than 300 bytes: level flag
// RL8: Transmitting, under 200 bytes: level flag
// RL9: Suppressed frame raises restart flag
// RL10: Timer/field status mirrors mask order
// RL11: Host clears collision flag before avoidance
// RL12: No field: field on, guard flag
// RL13: Timer/field status clears on read
// RL14: Field rise and drop flags
// RL15: Target mode bit rate recognised flag
// RL16: Main status clears on read
// RL17: Error/wake status matches its mask
// RL18: Target status matches its mask
// RL19: Main mask gates main flags
// RL20: Interrupt while unmasked flag pending
module nfcim_top (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  osc_en,
  input  wire logic                  osc_stable,
  input  wire logic                  rx_active,
  input  wire logic                  tx_active,
  input  wire nfcim_pkg::nfcim_count_t fifo_count,
  input  wire logic                  rx_start,
  input  wire logic                  rx_end,
  input  wire logic                  tx_end,
  input  wire logic                  bit_collision,
  input  wire logic                  em_disturbance,
  input  wire logic                  cmd_done,
  input  wire logic                  nrt_expire,
  input  wire logic                  gpt_expire,
  input  wire logic                  ext_field,
  input  wire logic                  ca_start,
  input  wire logic                  field_off,
  input  wire logic                  target_mode,
  input  wire logic                  bitrate_found,
  input  wire nfcim_pkg::nfcim_byte_t err_wake_evt,
  input  wire nfcim_pkg::nfcim_byte_t target_evt,
  output logic                       field_on,
  output logic                       irq
);
  import nfcim_pkg::*;

  // ============================================================
  // Decode helpers
  function automatic logic is_mask(input nfcim_idx_t idx);
    is_mask = (idx >= `NFCIM_IDX_MAIN_MASK) && (idx <= `NFCIM_IDX_PT_MASK);
  endfunction

  function automatic logic is_mapped(input nfcim_idx_t idx);
    is_mapped = (idx >= `NFCIM_IDX_MAIN_MASK) && (idx <= `NFCIM_IDX_PT_STAT);
  endfunction

  function automatic logic rise(input logic cur, input logic prev);
    rise = cur && !prev;
  endfunction

  // ============================================================
  // Bus slave
  nfcim_reg_if rb();

  nfcim_axil_slave u_slave (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .rb            (rb)
  );

  // Status registers are read-only; writes get an error
  assign rb.whit = is_mask(rb.widx);
  assign rb.rhit = is_mapped(rb.ridx);

  // ============================================================
  // Mask registers
  nfcim_byte_t main_mask_q, main_mask_d;
  nfcim_byte_t tf_mask_q, tf_mask_d;
  nfcim_byte_t ew_mask_q, ew_mask_d;
  nfcim_byte_t pt_mask_q, pt_mask_d;

  always_comb begin
    main_mask_d = main_mask_q;
    tf_mask_d = tf_mask_q;
    ew_mask_d = ew_mask_q;
    pt_mask_d = pt_mask_q;
    if (rb.wr) begin
      case (rb.widx)
        `NFCIM_IDX_MAIN_MASK: main_mask_d = rb.wdata & `NFCIM_MAIN_USED; // RL19
        `NFCIM_IDX_TF_MASK:   tf_mask_d = rb.wdata & `NFCIM_TF_USED; // RL1
        `NFCIM_IDX_EW_MASK:   ew_mask_d = rb.wdata & `NFCIM_EW_USED; // RL2
        `NFCIM_IDX_PT_MASK:   pt_mask_d = rb.wdata & `NFCIM_PT_USED; // RL3
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      main_mask_q <= `NFCIM_MASK_RST; // RL4
      tf_mask_q <= `NFCIM_MASK_RST;
      ew_mask_q <= `NFCIM_MASK_RST;
      pt_mask_q <= `NFCIM_MASK_RST;
    end else begin
      main_mask_q <= main_mask_d;
      tf_mask_q <= tf_mask_d;
      ew_mask_q <= ew_mask_d;
      pt_mask_q <= pt_mask_d;
    end
  end

  // ============================================================
  // Edge history for level sources
  logic osc_ok_q, wl_q, ext_q;
  logic osc_ok_d, wl_d, ext_d;

  // Level sources flag only on an edge (ext_field on both edges), so a flag cleared
  // by a read stays clear while the level persists
  always_comb begin
    osc_ok_d = osc_en && osc_stable;
    wl_d = (rx_active && (fifo_count > `NFCIM_WL_RX_BYTES)) || // RL7
           (tx_active && (fifo_count < `NFCIM_WL_TX_BYTES)); // RL8
    ext_d = ext_field;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_ok_q <= 1'b0;
      wl_q <= 1'b0;
      ext_q <= 1'b0;
    end else begin
      osc_ok_q <= osc_ok_d;
      wl_q <= wl_d;
      ext_q <= ext_d;
    end
  end

  // ============================================================
  // Collision avoidance and guard time
  localparam logic [15:0] GUARD_CYC = 16'(`NFCIM_GUARD_CYC);
  nfcim_ca_t   ca_q, ca_d;
  logic [15:0] gcnt_q, gcnt_d;
  logic        field_q, field_d;
  logic        cac_evt, cat_evt;

  always_comb begin
    ca_d = ca_q;
    gcnt_d = gcnt_q;
    field_d = field_q && !field_off;
    cac_evt = 1'b0;
    cat_evt = 1'b0;
    case (ca_q)
      CA_IDLE: begin
        if (ca_start) begin
          if (ext_field) begin
            cac_evt = 1'b1;
          end else begin
            field_d = 1'b1; // RL12
            gcnt_d = GUARD_CYC - 16'h0001;
            ca_d = CA_GUARD;
          end
        end
      end
      CA_GUARD: begin
        if (gcnt_q == 16'h0000) begin
          cat_evt = 1'b1; // RL12
          ca_d = CA_IDLE;
        end else begin
          gcnt_d = gcnt_q - 16'h0001;
        end
      end
      default: ca_d = CA_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ca_q <= CA_IDLE;
      gcnt_q <= 16'h0000;
      field_q <= 1'b0;
    end else begin
      ca_q <= ca_d;
      gcnt_q <= gcnt_d;
      field_q <= field_d;
    end
  end

  assign field_on = field_q;

  // ============================================================
  // Flag banks
  nfcim_flag_if main_fi();
  nfcim_flag_if tf_fi();
  nfcim_flag_if ew_fi();
  nfcim_flag_if pt_fi();

  always_comb begin
    main_fi.set = 8'h00;
    main_fi.set[`NFCIM_MAIN_OSC] = rise(osc_ok_d, osc_ok_q); // RL6
    main_fi.set[`NFCIM_MAIN_WL] = rise(wl_d, wl_q); // RL7
    main_fi.set[`NFCIM_MAIN_RXS] = rx_start; // RL5
    main_fi.set[`NFCIM_MAIN_RXE] = rx_end; // RL5
    main_fi.set[`NFCIM_MAIN_TXE] = tx_end; // RL5
    main_fi.set[`NFCIM_MAIN_COL] = bit_collision; // RL5
    main_fi.set[`NFCIM_MAIN_REST] = em_disturbance; // RL9
  end

  always_comb begin
    tf_fi.set = 8'h00;
    tf_fi.set[`NFCIM_TF_DCT] = cmd_done; // RL10
    tf_fi.set[`NFCIM_TF_NRE] = nrt_expire; // RL10
    tf_fi.set[`NFCIM_TF_GPE] = gpt_expire; // RL10
    tf_fi.set[`NFCIM_TF_EON] = rise(ext_d, ext_q); // RL14
    tf_fi.set[`NFCIM_TF_EOF] = rise(ext_q, ext_d); // RL14
    tf_fi.set[`NFCIM_TF_CAC] = cac_evt; // RL10
    tf_fi.set[`NFCIM_TF_CAT] = cat_evt; // RL12
    tf_fi.set[`NFCIM_TF_NFCT] = bitrate_found && target_mode; // RL15
  end

  assign ew_fi.set = err_wake_evt; // RL17
  assign pt_fi.set = target_evt; // RL18

  assign main_fi.mask = main_mask_q; // RL19
  assign tf_fi.mask = tf_mask_q; // RL4
  assign ew_fi.mask = ew_mask_q; // RL17
  assign pt_fi.mask = pt_mask_q; // RL18

  // Clear on the read; the slave latches the old value
  assign main_fi.clr = rb.rd && (rb.ridx == `NFCIM_IDX_MAIN_STAT); // RL16
  assign tf_fi.clr = rb.rd && (rb.ridx == `NFCIM_IDX_TF_STAT); // RL13
  assign ew_fi.clr = rb.rd && (rb.ridx == `NFCIM_IDX_EW_STAT);
  assign pt_fi.clr = rb.rd && (rb.ridx == `NFCIM_IDX_PT_STAT);

  nfcim_flag_bank #(.USED(`NFCIM_MAIN_USED)) u_main (
    .aclk    (aclk),
    .aresetn (aresetn),
    .fb      (main_fi)
  );

  nfcim_flag_bank #(.USED(`NFCIM_TF_USED)) u_tf (
    .aclk    (aclk),
    .aresetn (aresetn),
    .fb      (tf_fi)
  );

  nfcim_flag_bank #(.USED(`NFCIM_EW_USED)) u_ew (
    .aclk    (aclk),
    .aresetn (aresetn),
    .fb      (ew_fi)
  );

  nfcim_flag_bank #(.USED(`NFCIM_PT_USED)) u_pt (
    .aclk    (aclk),
    .aresetn (aresetn),
    .fb      (pt_fi)
  );

  // ============================================================
  // Read data
  always_comb begin
    case (rb.ridx)
      `NFCIM_IDX_MAIN_MASK: rb.rdata = main_mask_q;
      `NFCIM_IDX_TF_MASK:   rb.rdata = tf_mask_q;
      `NFCIM_IDX_EW_MASK:   rb.rdata = ew_mask_q;
      `NFCIM_IDX_PT_MASK:   rb.rdata = pt_mask_q;
      `NFCIM_IDX_MAIN_STAT: rb.rdata = main_fi.flags; // RL5
      `NFCIM_IDX_TF_STAT:   rb.rdata = tf_fi.flags; // RL10
      `NFCIM_IDX_EW_STAT:   rb.rdata = ew_fi.flags; // RL17
      `NFCIM_IDX_PT_STAT:   rb.rdata = pt_fi.flags; // RL18
      default:              rb.rdata = 8'h00;
    endcase
  end

  // ============================================================
  // Registered interrupt, glitch free
  logic irq_q, irq_d;

  always_comb begin
    irq_d = main_fi.pend || tf_fi.pend || ew_fi.pend || pt_fi.pend; // RL20
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  assign irq = irq_q;
endmodule
`default_nettype wire

// ### test/nfcim_properties.sv
`timescale 1ns/100ps
`default_nettype none
module nfcim_properties (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        ext_field,
  input wire logic        ca_start,
  input wire logic        field_off,
  input wire logic        field_on
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ============================================================
  // Register bus answers
  chk_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("No bvalid");
  chk_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("bvalid dropped");
  chk_write_refused: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("Write taken in bvalid");
  chk_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("No rvalid");
  chk_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("rvalid dropped");
  chk_read_refused: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("Read taken in rvalid");
  chk_rdata_upper: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000) else $error("rdata[31:8] set");
  // ============================================================
  // Own field
  chk_peer_no_field: assert property (
    ca_start && ext_field && !field_on |=> !field_on) else $error("Field on with peer");
  chk_own_field_on: assert property (
    ca_start && !ext_field && !field_on && !field_off |=> field_on)
    else $error("Field not on");
  chk_field_drop: assert property (
    field_off && !ca_start |=> !field_on) else $error("Field not off");
endmodule
`default_nettype wire

// ### test/nfcim_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module nfcim_host_model (
  input  wire logic        aclk,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready,
  output logic             ca_start
);
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready, ca_start} = '0;
  end
  // ============================================================
  // Released payloads are inverted
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr  <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata  <= ~d;
      end
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr  <= ~a;
      end
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // ============================================================
  // Avoidance starts with a clean collision flag
  task automatic start_avoidance();
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(8'h6c, d, r);
    ca_start <= 1'b1;
    @(posedge aclk);
    ca_start <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### test/nfc_interrupt_mask_status_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "nfcim_regs.svh"
module nfc_interrupt_mask_status_tb_top;
  import nfcim_pkg::*;
  logic         aclk = 1'b0;
  logic         aresetn = 1'b0;
  logic [7:0]   awaddr, araddr;
  logic [31:0]  wdata, rdata, rd;
  logic [3:0]   wstrb;
  logic [1:0]   bresp, rresp, rs;
  logic         awvalid, awready, wvalid, wready, bvalid, bready;
  logic         arvalid, arready, rvalid, rready, ca_start, field_on, irq;
  logic [9:0]   ev = '0;
  logic         osc_en = 1'b0, osc_stable = 1'b0, rx_active = 1'b0, tx_active = 1'b0;
  logic         ext_field = 1'b0, target_mode = 1'b0;
  nfcim_count_t fifo_count = '0;
  nfcim_byte_t  ew_evt = '0, pt_evt = '0;
  int           n_errors = 0, total_checks = 0, cycles = 0;
  always #2.5 aclk = ~aclk;
  nfcim_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .osc_en(osc_en),
    .osc_stable(osc_stable), .rx_active(rx_active), .tx_active(tx_active),
    .fifo_count(fifo_count), .rx_start(ev[0]), .rx_end(ev[1]), .tx_end(ev[2]),
    .bit_collision(ev[3]), .em_disturbance(ev[4]), .cmd_done(ev[5]), .nrt_expire(ev[6]),
    .gpt_expire(ev[7]), .ext_field(ext_field), .ca_start(ca_start), .field_off(ev[9]),
    .target_mode(target_mode), .bitrate_found(ev[8]), .err_wake_evt(ew_evt),
    .target_evt(pt_evt), .field_on(field_on), .irq(irq));
  nfcim_host_model u_host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .ca_start(ca_start));
  // ============================================================
  // Shared helpers
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    u_host.axi_read(a, rd, rs);
    check(what, exp, rd);
  endtask
  task automatic pulse(input int b);
    @(posedge aclk);
    ev[b] <= 1'b1;
    @(posedge aclk);
    ev[b] <= 1'b0;
  endtask
  task automatic lvl(input nfcim_count_t c, input logic [31:0] exp);
    fifo_count <= c;
    repeat (3) @(posedge aclk);
    check("irq masked", 32'h0, {31'h0, irq});
    rd_chk("water level", 8'h68, exp);
  endtask
  task automatic final_report();
    $display("Checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ============================================================
  // Scenarios
  task automatic test_regs();
    logic [7:0] adr [3] = '{8'h5c, 8'h60, 8'h64};
    logic [7:0] used [3] = '{8'hff, 8'hfe, 8'hfb};
    for (int i = 0; i < 3; i++) begin
      rd_chk("mask reset", adr[i], 32'h0);
      u_host.axi_write(adr[i], 32'hffffffff, rs);
      rd_chk("mask bits", adr[i], {24'h0, used[i]});
      u_host.axi_write(adr[i], 32'h0, rs);
    end
    rd_chk("unmapped data", 8'hfc, 32'h0);
    check("unmapped resp", 32'h2, {30'h0, rs});
    u_host.axi_write(8'h68, 32'hff, rs);
    check("status write resp", 32'h2, {30'h0, rs});
  endtask
  task automatic test_main();
    for (int i = 0; i < 5; i++) begin
      pulse(i);
      repeat (2) @(posedge aclk);
      check("irq raised", 32'h1, {31'h0, irq});
      rd_chk("main flag", 8'h68, 32'h20 >> i);
      rd_chk("main cleared", 8'h68, 32'h0);
      check("irq released", 32'h0, {31'h0, irq});
    end
  endtask
  task automatic test_timer();
    pulse(8);
    for (int i = 5; i < 8; i++) pulse(i);
    ext_field <= 1'b1;
    repeat (3) @(posedge aclk);
    ext_field <= 1'b0;
    target_mode <= 1'b1;
    pulse(8);
    rd_chk("timer flags", 8'h6c, 32'hf9);
    rd_chk("timer cleared", 8'h6c, 32'h0);
    target_mode <= 1'b0;
  endtask
  task automatic test_masks();
    u_host.axi_write(8'h5c, 32'h80, rs);
    u_host.axi_write(8'h60, 32'hff, rs);
    u_host.axi_write(8'h64, 32'hff, rs);
    u_host.axi_write(8'h58, 32'h40, rs);
    pulse(5);
    {ew_evt, pt_evt} <= 16'hffff;
    @(posedge aclk);
    {ew_evt, pt_evt} <= 16'h0000;
    rx_active <= 1'b1;
    lvl(10'd300, 32'h0);
    lvl(10'd301, 32'h40);
    rx_active <= 1'b0;
    tx_active <= 1'b1;
    lvl(10'd200, 32'h0);
    lvl(10'd199, 32'h40);
    tx_active <= 1'b0;
    rd_chk("masked flag kept", 8'h6c, 32'h80);
    rd_chk("error flags", 8'h70, 32'hfe);
    rd_chk("target flags", 8'h74, 32'hfb);
  endtask
  task automatic test_osc();
    osc_en <= 1'b1;
    repeat (3) @(posedge aclk);
    rd_chk("osc not stable", 8'h68, 32'h0);
    osc_stable <= 1'b1;
    repeat (3) @(posedge aclk);
    check("irq osc", 32'h1, {31'h0, irq});
    rd_chk("osc stable", 8'h68, 32'h80);
  endtask
  task automatic test_avoid();
    ext_field <= 1'b1;
    u_host.start_avoidance();
    repeat (2) @(posedge aclk);
    check("field with peer", 32'h0, {31'h0, field_on});
    rd_chk("collision flag", 8'h6c, 32'h04);
    ext_field <= 1'b0;
    u_host.start_avoidance();
    repeat (2) @(posedge aclk);
    check("own field", 32'h1, {31'h0, field_on});
    repeat (`NFCIM_GUARD_CYC - 60) @(posedge aclk);
    rd_chk("guard pending", 8'h6c, 32'h0);
    repeat (60) @(posedge aclk);
    rd_chk("guard expired", 8'h6c, 32'h02);
    pulse(9);
    @(posedge aclk);
    check("field off", 32'h0, {31'h0, field_on});
  endtask
  // ============================================================
  // Sequence and hang guard
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      final_report();
    end
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    test_regs();
    test_main();
    test_timer();
    test_masks();
    test_osc();
    test_avoid();
    final_report();
  end
endmodule
bind nfcim_top nfcim_properties u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .ext_field, .ca_start,
  .field_off, .field_on);
`default_nettype wire
